// file: verilog/bslfg_pkg.sv
// package: function classes, register groups, widths, reset values
// assumes: shared by the logic group top and its register file
package bslfg_pkg;
   localparam int BSLFG_W = 2;
   localparam int BSLFG_NREG = 11;
   localparam int BSLFG_AW = 4;
   // register numbers: entries 0..8 general, 9 is aux, 10 is primary
   localparam logic [3:0] BSLFG_AUX_IDX = 4'h9;
   localparam logic [3:0] BSLFG_ACC_IDX = 4'ha;
   localparam logic [1:0] BSLFG_RST_VAL = 2'h0;
   localparam logic [1:0] BSLFG_MASK_ZERO = 2'h0;
   localparam logic [1:0] BSLFG_MASK_ONES = 2'h3;
   typedef enum logic [2:0] {
      BSLFG_F_OTHER = 3'h0,
      BSLFG_F_AND_MASK = 3'h5,
      BSLFG_F_OR_MASK = 3'h6,
      BSLFG_F_XNOR_MASK = 3'h7
   } bslfg_fclass_e;
   typedef enum logic [1:0] {
      BSLFG_G_NONE = 2'h0,
      BSLFG_G_FILE = 2'h1,
      BSLFG_G_LOAD = 2'h2,
      BSLFG_G_EXT = 2'h3
   } bslfg_rgroup_e;
endpackage

// file: verilog/bslfg_regfile.sv
// register file of the slice: two-bit entries, one write port
// assumes: write port is driven by the logic group top on sys_clk_i
`timescale 1ns/100ps
module bslfg_regfile
   import bslfg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [BSLFG_AW-1:0] wr_idx_i,
   input wire logic [BSLFG_W-1:0] wr_data_i,
   // read port
   input wire logic [BSLFG_AW-1:0] rd_idx_i,
   output logic [BSLFG_W-1:0] rd_data_o,
   output logic [BSLFG_W-1:0] acc_o,
   output logic [BSLFG_W-1:0] aux_o
);
   typedef struct packed {
      logic [BSLFG_NREG-1:0][BSLFG_W-1:0] mem;
   } bslfg_rf_s;
   bslfg_rf_s st_r;
   bslfg_rf_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (wr_en_i && (wr_idx_i < BSLFG_AW'(BSLFG_NREG)))
      begin
         st_nxt.mem[wr_idx_i] = wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // out-of-range index reads zero
   assign rd_data_o = (rd_idx_i < BSLFG_AW'(BSLFG_NREG)) ?
                      st_r.mem[rd_idx_i] : BSLFG_RST_VAL;
   assign acc_o = st_r.mem[BSLFG_ACC_IDX];
   assign aux_o = st_r.mem[BSLFG_AUX_IDX];
endmodule // bslfg_regfile

// file: verilog/bslfg_top.sv
// logic function group of a two-bit slice: classes 5, 6 and 7
// assumes: function, buses and carry in are set up before the clock edge
//
// What this block does
// - class 5 group III: dst gets mask AND dst; carry ORs result
// - class 5 group III, zero mask: clear dst, carry out = carry in
// - class 5 group III, ones mask: dst kept, carry if dst nonzero
// - class 6 group I: entry ORs in acc AND mask; carry ORs that term
// - class 6 group I or III, zero mask: no change, carry passes
// - class 6 group I, ones mask: entry ORs acc; carry if acc nonzero
// - class 6 group II: dst gets load bus OR acc AND mask
// - class 6 group II, zero mask: dst loads load bus, carry passes
// - class 6 group II, ones mask: dst gets load OR acc
// - class 6 group III: dst ORs in ext AND mask; carry ORs that term
// - class 6 group III, ones mask: dst ORs ext; carry if ext nonzero
// - class 7 group I: entry XNOR acc AND mask; carry on entry AND term
// - class 7 group I, zero mask: complement entry, carry passes
// - class 7 group I, ones mask: entry XNOR acc; carry on acc AND entry
// - group I names any file entry; II and III hit acc or aux
`timescale 1ns/100ps
module bslfg_top
   import bslfg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // function code
   input wire bslfg_pkg::bslfg_fclass_e fclass_i,
   input wire bslfg_pkg::bslfg_rgroup_e rgroup_i,
   input wire logic [bslfg_pkg::BSLFG_AW-1:0] reg_idx_i,
   input wire logic dst_aux_i,
   // data buses
   input wire logic [bslfg_pkg::BSLFG_W-1:0] mask_bus_i,
   input wire logic [bslfg_pkg::BSLFG_W-1:0] load_bus_i,
   input wire logic [bslfg_pkg::BSLFG_W-1:0] ext_bus_i,
   input wire logic carry_in_i,
   // results
   output logic carry_out_o,
   output logic [bslfg_pkg::BSLFG_W-1:0] primary_work_reg_o,
   output logic [bslfg_pkg::BSLFG_W-1:0] aux_reg_o
);
   import bslfg_pkg::*;

   typedef struct packed {
      logic wr_en;
      logic [BSLFG_AW-1:0] wr_idx;
      logic [BSLFG_W-1:0] wr_data;
      logic carry;
   } bslfg_dp_s;

   bslfg_dp_s dp_nxt;
   logic [BSLFG_W-1:0] acc;
   logic [BSLFG_W-1:0] aux;
   logic [BSLFG_W-1:0] entry;
   logic [BSLFG_W-1:0] sel_dst;
   logic [BSLFG_AW-1:0] dst_idx;

   // group I reads the addressed entry; II and III use acc or aux
   assign dst_idx = dst_aux_i ? BSLFG_AUX_IDX : BSLFG_ACC_IDX;
   assign sel_dst = dst_aux_i ? aux : acc;

   bslfg_regfile u_regfile (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_en_i(dp_nxt.wr_en),
      .wr_idx_i(dp_nxt.wr_idx),
      .wr_data_i(dp_nxt.wr_data),
      .rd_idx_i(reg_idx_i),
      .rd_data_o(entry),
      .acc_o(acc),
      .aux_o(aux)
   );

   // the general masked equations cover the 00 and 11 masks too
   always_comb
   begin
      dp_nxt = '0;
      dp_nxt.carry = carry_in_i;
      unique case (fclass_i)
         BSLFG_F_AND_MASK:
         begin
            if (rgroup_i == BSLFG_G_EXT)
            begin
               dp_nxt.wr_en = 1'b1;
               dp_nxt.wr_idx = dst_idx;
               dp_nxt.wr_data = mask_bus_i & sel_dst;
               dp_nxt.carry = carry_in_i | (|(mask_bus_i & sel_dst));
            end
         end
         BSLFG_F_OR_MASK:
         begin
            unique case (rgroup_i)
               BSLFG_G_FILE:
               begin
                  dp_nxt.wr_en = 1'b1;
                  dp_nxt.wr_idx = reg_idx_i;
                  dp_nxt.wr_data = entry | (acc & mask_bus_i);
                  dp_nxt.carry = carry_in_i | (|(acc & mask_bus_i));
               end
               BSLFG_G_LOAD:
               begin
                  dp_nxt.wr_en = 1'b1;
                  dp_nxt.wr_idx = dst_idx;
                  dp_nxt.wr_data = load_bus_i | (acc & mask_bus_i);
                  dp_nxt.carry = carry_in_i | (|(acc & mask_bus_i));
               end
               BSLFG_G_EXT:
               begin
                  dp_nxt.wr_en = 1'b1;
                  dp_nxt.wr_idx = dst_idx;
                  dp_nxt.wr_data = sel_dst | (ext_bus_i & mask_bus_i);
                  dp_nxt.carry = carry_in_i | (|(ext_bus_i & mask_bus_i));
               end
               BSLFG_G_NONE:
               begin
                  dp_nxt.wr_en = 1'b0;
               end
            endcase
         end
         BSLFG_F_XNOR_MASK:
         begin
            if (rgroup_i == BSLFG_G_FILE)
            begin
               dp_nxt.wr_en = 1'b1;
               dp_nxt.wr_idx = reg_idx_i;
               dp_nxt.wr_data = ~(entry ^ (acc & mask_bus_i));
               dp_nxt.carry = carry_in_i | (|(entry & acc & mask_bus_i));
            end
         end
         default:
         begin
            dp_nxt.wr_en = 1'b0;
         end
      endcase
   end

   // carry follows inputs combinationally; registers change at the edge
   assign carry_out_o = dp_nxt.carry;
   assign primary_work_reg_o = acc;
   assign aux_reg_o = aux;

   property p_cls5_and;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_AND_MASK && rgroup_i == BSLFG_G_EXT && !dst_aux_i)
      |=> (acc == ($past(mask_bus_i) & $past(acc)));
   endproperty
   a_cls5_and: assert property (p_cls5_and)
      else $error("class 5 masked and result wrong");

   property p_cls5_clr;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_AND_MASK && rgroup_i == BSLFG_G_EXT &&
       mask_bus_i == BSLFG_MASK_ZERO)
      |-> (carry_out_o == carry_in_i) ##1
          (($past(dst_aux_i) ? aux : acc) == BSLFG_RST_VAL);
   endproperty
   a_cls5_clr: assert property (p_cls5_clr)
      else $error("class 5 clear failed");

   property p_cls5_tz;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_AND_MASK && rgroup_i == BSLFG_G_EXT &&
       mask_bus_i == BSLFG_MASK_ONES)
      |-> (carry_out_o == (carry_in_i | (|sel_dst)));
   endproperty
   a_cls5_tz: assert property (p_cls5_tz)
      else $error("class 5 zero test carry wrong");

   property p_cls6_nop;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_OR_MASK && rgroup_i == BSLFG_G_EXT &&
       mask_bus_i == BSLFG_MASK_ZERO)
      |-> (carry_out_o == carry_in_i) ##1 $stable(acc) && $stable(aux);
   endproperty
   a_cls6_nop: assert property (p_cls6_nop)
      else $error("class 6 null operation changed state");

   property p_cls6_ld;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_OR_MASK && rgroup_i == BSLFG_G_LOAD && dst_aux_i)
      |=> (aux == ($past(load_bus_i) | ($past(acc) & $past(mask_bus_i))));
   endproperty
   a_cls6_ld: assert property (p_cls6_ld)
      else $error("class 6 load bus result wrong");

   property p_cls6_ext;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_OR_MASK && rgroup_i == BSLFG_G_EXT)
      |-> (carry_out_o == (carry_in_i | (|(ext_bus_i & mask_bus_i))));
   endproperty
   a_cls6_ext: assert property (p_cls6_ext)
      else $error("class 6 ext bus carry wrong");

   property p_cls6_file;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_OR_MASK && rgroup_i == BSLFG_G_FILE &&
       reg_idx_i == BSLFG_AUX_IDX)
      |=> (aux == ($past(aux) | ($past(acc) & $past(mask_bus_i))));
   endproperty
   a_cls6_file: assert property (p_cls6_file)
      else $error("class 6 file or result wrong");

   property p_cls7_cmp;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_XNOR_MASK && rgroup_i == BSLFG_G_FILE &&
       reg_idx_i == BSLFG_AUX_IDX && mask_bus_i == BSLFG_MASK_ZERO)
      |=> (aux == ~$past(aux));
   endproperty
   a_cls7_cmp: assert property (p_cls7_cmp)
      else $error("class 7 complement failed");

   property p_cls7_co;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fclass_i == BSLFG_F_XNOR_MASK && rgroup_i == BSLFG_G_FILE)
      |-> (carry_out_o == (carry_in_i | (|(entry & acc & mask_bus_i))));
   endproperty
   a_cls7_co: assert property (p_cls7_co)
      else $error("class 7 carry wrong");

   c_cls5: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      fclass_i == BSLFG_F_AND_MASK && rgroup_i == BSLFG_G_EXT && carry_out_o);
   c_cls6: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      fclass_i == BSLFG_F_OR_MASK && rgroup_i == BSLFG_G_LOAD);
   c_cls7: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      fclass_i == BSLFG_F_XNOR_MASK && rgroup_i == BSLFG_G_FILE);
endmodule // bslfg_top

// file: dv/bslfg_ctl_model.sv
// partner model: microprogram control splitting a control word into
// function code, mask, load and ext buses and carry in
// assumes: word changes only at the falling edge of the slice clock
`timescale 1ns/100ps
module bslfg_ctl_model
   import bslfg_pkg::*;
(
   // control word
   input wire logic [31:0] word_i,
   // toward the slice
   output bslfg_pkg::bslfg_fclass_e fclass_o,
   output bslfg_pkg::bslfg_rgroup_e rgroup_o,
   output logic [3:0] reg_idx_o,
   output logic dst_aux_o,
   output logic [1:0] mask_bus_o,
   output logic [1:0] load_bus_o,
   output logic [1:0] ext_bus_o,
   output logic carry_in_o
);
   // fields stand the whole cycle around the rising edge
   always_comb
   begin
      fclass_o = bslfg_fclass_e'(word_i[2:0]);
      rgroup_o = bslfg_rgroup_e'(word_i[4:3]);
      reg_idx_o = word_i[8:5];
      dst_aux_o = word_i[9];
      mask_bus_o = word_i[11:10];
      load_bus_o = word_i[13:12];
      ext_bus_o = word_i[15:14];
      carry_in_o = word_i[16];
   end
endmodule // bslfg_ctl_model

// file: dv/test_bitslice_logic_function_group.sv
// testbench: random control words against an integer model of the slice
// assumes: inputs change at the falling edge, registers checked a cycle on, carry 1 ns after
`timescale 1ns/100ps
module test_bitslice_logic_function_group;
   import bslfg_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] word = 32'h0;
   bslfg_fclass_e fclass;
   bslfg_rgroup_e rgroup;
   logic [3:0] reg_idx;
   logic dst_aux, carry_in, carry_out;
   logic [1:0] mask_bus, load_bus, ext_bus, acc_q, aux_q;
   int errors = 0;
   int n_checks = 0;
   int m[0:15];
   bslfg_ctl_model ctl (.word_i(word), .fclass_o(fclass), .rgroup_o(rgroup),
      .reg_idx_o(reg_idx), .dst_aux_o(dst_aux), .mask_bus_o(mask_bus),
      .load_bus_o(load_bus), .ext_bus_o(ext_bus), .carry_in_o(carry_in));
   bslfg_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .fclass_i(fclass),
      .rgroup_i(rgroup), .reg_idx_i(reg_idx), .dst_aux_i(dst_aux),
      .mask_bus_i(mask_bus), .load_bus_i(load_bus), .ext_bus_i(ext_bus),
      .carry_in_i(carry_in), .carry_out_o(carry_out),
      .primary_work_reg_o(acc_q), .aux_reg_o(aux_q));
   initial
   begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk(input string nm, input logic [1:0] ex,
      input logic [1:0] got);
      n_checks++;
      if (got !== ex)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #40000;
      errors++;
      tally_and_finish();
   end
   initial
   begin
      logic [31:0] w;
      int f, g, x, d, k, ld, ex, ci, acc, e, t, co;
      w = 32'd91666;
      for (int i = 0; i < 16; i++)
         m[i] = 0;
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      for (int i = 0; i < 1500; i++)
      begin
         @(negedge sys_clk_i);
         chk("primary", 2'(m[10]), acc_q);
         chk("aux", 2'(m[9]), aux_q);
         w = xs(w);
         word = w;
         #1;
         f = int'(w[2:0]);
         g = int'(w[4:3]);
         x = int'(w[8:5]);
         d = w[9] ? int'(BSLFG_AUX_IDX) : int'(BSLFG_ACC_IDX);
         k = int'(w[11:10]);
         ld = int'(w[13:12]);
         ex = int'(w[15:14]);
         ci = int'(w[16]);
         acc = m[10];
         e = (x <= 10) ? m[x] : 0;
         co = ci;
         t = 0;
         if (f == 5 && g == 3)
         begin
            t = k & m[d];
            m[d] = t;
         end
         else if (f == 6 && g == 1)
         begin
            t = acc & k;
            if (x <= 10) m[x] = e | t;
         end
         else if (f == 6 && g == 2)
         begin
            t = acc & k;
            m[d] = ld | t;
         end
         else if (f == 6 && g == 3)
         begin
            t = ex & k;
            m[d] = m[d] | t;
         end
         else if (f == 7 && g == 1)
         begin
            t = e & acc & k;
            if (x <= 10) m[x] = ~(e ^ (acc & k)) & 3;
         end
         co = ci | (t != 0);
         chk("carry_out", 2'(co), {1'b0, carry_out});
      end
      // the last op's effect on primary and aux is covered by these compares:
      @(negedge sys_clk_i);
      chk("primary", 2'(m[10]), acc_q);
      chk("aux", 2'(m[9]), aux_q);
      tally_and_finish();
   end
endmodule // test_bitslice_logic_function_group
